// ### logic/art2_pkg.sv
`default_nettype none
package art2_pkg;
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned BYTE_W = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_RELOAD_LO  = 8'h00;
  localparam logic [7:0] ADDR_RELOAD_HI  = 8'h04;
  localparam logic [7:0] ADDR_COUNT_LO   = 8'h08;
  localparam logic [7:0] ADDR_COUNT_HI   = 8'h0C;
  localparam logic [7:0] ADDR_CLK_SELECT = 8'h10;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1C;
  localparam logic [7:0] ADDR_CONTROL    = 8'hC8;

  // timer_overflow_control fields
  localparam int unsigned CTL_HIGH_FLAG = 7;
  localparam int unsigned CTL_LOW_FLAG  = 6;
  localparam int unsigned CTL_LOW_IRQEN = 5;
  localparam int unsigned CTL_SPLIT     = 3;
  localparam int unsigned CTL_RUN       = 2;
  localparam int unsigned CTL_EXT_CLK   = 0;
  localparam logic [7:0]  CTL_WMASK     = 8'hED;

  // clock_select_register fields
  localparam int unsigned CKS_LOW  = 0;
  localparam int unsigned CKS_HIGH = 1;
  localparam int unsigned CKS_W    = 2;

  // interrupt_enable_register field
  localparam int unsigned IEN_TIMER = 0;

  // irq status / mask fields
  localparam int unsigned STS_HIGH = 0;
  localparam int unsigned STS_LOW  = 1;
  localparam int unsigned STS_W    = 2;

  localparam logic [7:0]        RST_BYTE  = 8'h00;
  localparam logic [7:0]        BYTE_MAX  = 8'hFF;
  localparam logic [7:0]        BYTE_ZERO = 8'h00;
  localparam logic [APB_DW-1:0] RD_ZERO   = 32'h0000_0000;

  localparam int unsigned SYS_DIV = 12;
  localparam int unsigned EXT_DIV = 8;
endpackage
`default_nettype wire

// ### logic/art2_clk_src.sv
`timescale 1ns/1ps
`default_nettype none
module art2_clk_src #(
  parameter int unsigned SYS_DIV = art2_pkg::SYS_DIV,
  parameter int unsigned EXT_DIV = art2_pkg::EXT_DIV
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic ext_osc,
  output logic      sys_tick,
  output logic      ext_tick
);
  localparam int unsigned SW = $clog2(SYS_DIV);
  localparam int unsigned EW = $clog2(EXT_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

  logic [SW-1:0] sys_cnt_ff;
  logic [EW-1:0] ext_cnt_ff;
  logic          sync1_ff;
  logic          sync2_ff;
  logic          sync3_ff;
  logic          level_ff;
  logic          rise;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sys_cnt_ff <= '0;
      sys_tick   <= 1'b0;
    end else begin
      sys_tick   <= (sys_cnt_ff == SYS_LAST);
      sys_cnt_ff <= (sys_cnt_ff == SYS_LAST) ? '0 : sys_cnt_ff + SW'(1);
    end
  end

  // oscillator is asynchronous: three stages, change taken when stages 2 and 3 agree
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      sync1_ff <= ext_osc;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        level_ff <= sync3_ff;
      end
    end
  end

  assign rise = (sync2_ff == sync3_ff) & sync3_ff & ~level_ff;

  // limitation: oscillator must stay below about a sixth of core_clk
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_cnt_ff <= '0;
      ext_tick   <= 1'b0;
    end else begin
      ext_tick <= rise & (ext_cnt_ff == EXT_LAST);
      if (rise) begin
        ext_cnt_ff <= (ext_cnt_ff == EXT_LAST) ? '0 : ext_cnt_ff + EW'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/art2_top.sv
// Operation
// - split select zero gives one 16-bit counter with auto reload.
// - split select one gives two independent auto-reloading 8-bit counters.
// - 16-bit wrap loads both reload bytes and sets the high overflow flag.
// - 16-bit mode with timer interrupt enabled and high irq mask bit set requests interrupt every overflow.
// - 16-bit mode, low irq enable also requests on each low-byte wrap.
// - split mode reloads each byte from its own reload register.
// - split mode run bit gates high byte only; low byte always counts.
// - clock select one gives system clock, else div12 or external div8.
// - external divided-by-8 source synchronised to system clock before counting.
// - split mode sets high flag on high wrap, low flag on low wrap.
// - split mode interrupts on high wrap, either wrap with low irq enable.
// - hardware never clears overflow flags; only a software zero write does.
`timescale 1ns/1ps
`default_nettype none
module art2_top (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [art2_pkg::APB_AW-1:0]   paddr,
  input  wire logic [art2_pkg::APB_DW-1:0]   pwdata,
  output logic      [art2_pkg::APB_DW-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          ext_osc,
  output logic                               irq
);
  localparam int unsigned BW = art2_pkg::BYTE_W;
  localparam int unsigned SW = art2_pkg::STS_W;

  logic [BW-1:0] reload_low_byte_ff;
  logic [BW-1:0] reload_high_byte_ff;
  logic [BW-1:0] count_low_byte_ff;
  logic [BW-1:0] count_high_byte_ff;
  logic [BW-1:0] timer_overflow_control_ff;
  logic [art2_pkg::CKS_W-1:0] clock_select_ff;
  logic          timer_irq_enable_ff;
  logic [SW-1:0] irq_status_ff;
  logic [SW-1:0] irq_mask_ff;
  logic          slverr_ff;

  logic sys_tick;
  logic ext_tick;
  logic split;
  logic run;
  logic ext_sel;
  logic tick_low;
  logic tick_high;
  logic inc_low;
  logic inc_high;
  logic wrap_low;
  logic wrap_high;
  logic setup;
  logic wr_en;
  logic [BW-1:0] wbyte;
  logic [SW-1:0] sts_set;

  function automatic logic addr_hit(input logic [art2_pkg::APB_AW-1:0] a);
    unique case (a)
      art2_pkg::ADDR_RELOAD_LO, art2_pkg::ADDR_RELOAD_HI,
      art2_pkg::ADDR_COUNT_LO, art2_pkg::ADDR_COUNT_HI,
      art2_pkg::ADDR_CLK_SELECT, art2_pkg::ADDR_INT_ENABLE,
      art2_pkg::ADDR_IRQ_STATUS, art2_pkg::ADDR_IRQ_MASK,
      art2_pkg::ADDR_CONTROL: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  function automatic logic wr_to(input logic [art2_pkg::APB_AW-1:0] a,
                                 input logic [art2_pkg::APB_AW-1:0] reg_addr,
                                 input logic en);
    wr_to = en & (a == reg_addr);
  endfunction

  // select one of the three count sources for a byte
  function automatic logic tick_pick(input logic sys_sel, input logic xsel,
                                     input logic div12, input logic ext8);
    tick_pick = sys_sel ? 1'b1 : (xsel ? ext8 : div12);
  endfunction

  art2_clk_src #(
    .SYS_DIV (art2_pkg::SYS_DIV),
    .EXT_DIV (art2_pkg::EXT_DIV)
  ) u_clk_src (
    .core_clk (core_clk),
    .reset    (reset),
    .ext_osc  (ext_osc),
    .sys_tick (sys_tick),
    .ext_tick (ext_tick)
  );

  assign split   = timer_overflow_control_ff[art2_pkg::CTL_SPLIT];
  assign run     = timer_overflow_control_ff[art2_pkg::CTL_RUN];
  assign ext_sel = timer_overflow_control_ff[art2_pkg::CTL_EXT_CLK];

  // ---------------- counting ----------------
  assign tick_low = tick_pick(clock_select_ff[art2_pkg::CKS_LOW], ext_sel,
                              sys_tick, ext_tick);
  assign tick_high = split ? tick_pick(clock_select_ff[art2_pkg::CKS_HIGH], ext_sel,
                                       sys_tick, ext_tick)
                           : tick_low;
  assign inc_low   = tick_low & (split | run);
  assign wrap_low  = inc_low & (count_low_byte_ff == art2_pkg::BYTE_MAX);
  // in 16-bit mode the high byte is carried by the low byte
  assign inc_high  = split ? (tick_high & run) : wrap_low;
  assign wrap_high = inc_high & (count_high_byte_ff == art2_pkg::BYTE_MAX);

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign wbyte = pwdata[BW-1:0];

  // software write to a count byte wins over counting in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_low_byte_ff <= art2_pkg::RST_BYTE;
    end else if (wr_to(paddr, art2_pkg::ADDR_COUNT_LO, wr_en)) begin
      count_low_byte_ff <= wbyte;
    end else if (wrap_low) begin
      if (split || wrap_high) begin
        count_low_byte_ff <= reload_low_byte_ff;
      end else begin
        count_low_byte_ff <= art2_pkg::BYTE_ZERO;
      end
    end else if (inc_low) begin
      count_low_byte_ff <= count_low_byte_ff + BW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_high_byte_ff <= art2_pkg::RST_BYTE;
    end else if (wr_to(paddr, art2_pkg::ADDR_COUNT_HI, wr_en)) begin
      count_high_byte_ff <= wbyte;
    end else if (wrap_high) begin
      count_high_byte_ff <= reload_high_byte_ff;
    end else if (inc_high) begin
      count_high_byte_ff <= count_high_byte_ff + BW'(1);
    end
  end

  // ---------------- registers ----------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reload_low_byte_ff  <= art2_pkg::RST_BYTE;
      reload_high_byte_ff <= art2_pkg::RST_BYTE;
      clock_select_ff     <= '0;
      timer_irq_enable_ff <= 1'b0;
      irq_mask_ff         <= '0;
    end else begin
      if (wr_to(paddr, art2_pkg::ADDR_RELOAD_LO, wr_en)) begin
        reload_low_byte_ff <= wbyte;
      end
      if (wr_to(paddr, art2_pkg::ADDR_RELOAD_HI, wr_en)) begin
        reload_high_byte_ff <= wbyte;
      end
      if (wr_to(paddr, art2_pkg::ADDR_CLK_SELECT, wr_en)) begin
        clock_select_ff <= pwdata[art2_pkg::CKS_W-1:0];
      end
      if (wr_to(paddr, art2_pkg::ADDR_INT_ENABLE, wr_en)) begin
        timer_irq_enable_ff <= pwdata[art2_pkg::IEN_TIMER];
      end
      if (wr_to(paddr, art2_pkg::ADDR_IRQ_MASK, wr_en)) begin
        irq_mask_ff <= pwdata[SW-1:0];
      end
    end
  end

  // control: flags only change on hardware set or software write; set wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_overflow_control_ff <= art2_pkg::RST_BYTE;
    end else begin
      if (wr_to(paddr, art2_pkg::ADDR_CONTROL, wr_en)) begin
        timer_overflow_control_ff <= wbyte & art2_pkg::CTL_WMASK;
      end
      if (wrap_high) begin
        timer_overflow_control_ff[art2_pkg::CTL_HIGH_FLAG] <= 1'b1;
      end
      if (wrap_low) begin
        timer_overflow_control_ff[art2_pkg::CTL_LOW_FLAG] <= 1'b1;
      end
    end
  end

  // ---------------- interrupts ----------------
  always_comb begin
    sts_set = '0;
    sts_set[art2_pkg::STS_HIGH] = wrap_high;
    sts_set[art2_pkg::STS_LOW]  = wrap_low &
      timer_overflow_control_ff[art2_pkg::CTL_LOW_IRQEN];
  end

  // write one to clear; a new event in the same cycle survives
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_status_ff <= '0;
    end else if (wr_to(paddr, art2_pkg::ADDR_IRQ_STATUS, wr_en)) begin
      irq_status_ff <= (irq_status_ff & ~pwdata[SW-1:0]) | sts_set;
    end else begin
      irq_status_ff <= irq_status_ff | sts_set;
    end
  end

  assign irq = timer_irq_enable_ff & (|(irq_status_ff & irq_mask_ff));

  // ---------------- APB read side ----------------
  // read data sampled in the setup cycle so it comes from a flop; zero wait states
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata    <= art2_pkg::RD_ZERO;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      slverr_ff <= ~addr_hit(paddr);
      prdata    <= art2_pkg::RD_ZERO;
      if (!pwrite) begin
        unique case (paddr)
          art2_pkg::ADDR_RELOAD_LO:  prdata[BW-1:0] <= reload_low_byte_ff;
          art2_pkg::ADDR_RELOAD_HI:  prdata[BW-1:0] <= reload_high_byte_ff;
          art2_pkg::ADDR_COUNT_LO:   prdata[BW-1:0] <= count_low_byte_ff;
          art2_pkg::ADDR_COUNT_HI:   prdata[BW-1:0] <= count_high_byte_ff;
          art2_pkg::ADDR_CLK_SELECT: prdata[art2_pkg::CKS_W-1:0] <= clock_select_ff;
          art2_pkg::ADDR_INT_ENABLE: prdata[art2_pkg::IEN_TIMER] <= timer_irq_enable_ff;
          art2_pkg::ADDR_IRQ_STATUS: prdata[SW-1:0] <= irq_status_ff;
          art2_pkg::ADDR_IRQ_MASK:   prdata[SW-1:0] <= irq_mask_ff;
          art2_pkg::ADDR_CONTROL:    prdata[BW-1:0] <= timer_overflow_control_ff;
          default:                   prdata <= art2_pkg::RD_ZERO;
        endcase
      end
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & slverr_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_ctl;
  assign wr_cnt_lo = wr_to(paddr, art2_pkg::ADDR_COUNT_LO, wr_en);
  assign wr_cnt_hi = wr_to(paddr, art2_pkg::ADDR_COUNT_HI, wr_en);
  assign wr_ctl    = wr_to(paddr, art2_pkg::ADDR_CONTROL, wr_en);

  AST_FULL_WRAP_RELOAD: assert property (
    (!split && inc_low && count_low_byte_ff == art2_pkg::BYTE_MAX &&
     count_high_byte_ff == art2_pkg::BYTE_MAX && !wr_cnt_lo && !wr_cnt_hi && !wr_ctl)
    |=> (count_low_byte_ff == $past(reload_low_byte_ff)) &&
        (count_high_byte_ff == $past(reload_high_byte_ff)) &&
        timer_overflow_control_ff[art2_pkg::CTL_HIGH_FLAG])
    else $error("16-bit wrap did not reload or set high flag");

  AST_LOW_CARRY: assert property (
    (!split && wrap_low && count_high_byte_ff != art2_pkg::BYTE_MAX &&
     !wr_cnt_lo && !wr_cnt_hi)
    |=> count_low_byte_ff == art2_pkg::BYTE_ZERO &&
        count_high_byte_ff == $past(count_high_byte_ff) + BW'(1))
    else $error("16-bit carry into high byte wrong");

  AST_SPLIT_LOW_RELOAD: assert property (
    (split && wrap_low && !wr_cnt_lo) |=> count_low_byte_ff == $past(reload_low_byte_ff))
    else $error("split low byte did not reload");

  AST_SPLIT_LOW_FREE: assert property (
    (split && !run && tick_low && count_low_byte_ff != art2_pkg::BYTE_MAX && !wr_cnt_lo)
    |=> count_low_byte_ff == $past(count_low_byte_ff) + BW'(1))
    else $error("split low byte stopped by run bit");

  AST_HOLD_STOPPED: assert property (
    (!split && !run && !wr_cnt_lo && !wr_cnt_hi)
    |=> $stable(count_low_byte_ff) && $stable(count_high_byte_ff))
    else $error("stopped 16-bit counter moved");

  AST_SPLIT_HIGH_STOP: assert property (
    (split && !run && !wr_cnt_hi) |=> $stable(count_high_byte_ff))
    else $error("split high byte moved while stopped");

  AST_SYSTEM_CLOCK_SRC: assert property (
    (clock_select_ff[art2_pkg::CKS_LOW] && run && !split &&
     count_low_byte_ff != art2_pkg::BYTE_MAX && !wr_cnt_lo)
    |=> count_low_byte_ff == $past(count_low_byte_ff) + BW'(1))
    else $error("system clock source did not count every cycle");

  AST_FLAG_STICKY: assert property (
    (timer_overflow_control_ff[art2_pkg::CTL_HIGH_FLAG] && !wr_ctl)
    |=> timer_overflow_control_ff[art2_pkg::CTL_HIGH_FLAG])
    else $error("high flag cleared by hardware");

  AST_LOW_FLAG: assert property (
    wrap_low |=> timer_overflow_control_ff[art2_pkg::CTL_LOW_FLAG])
    else $error("low flag not set on low wrap");

  AST_IRQ_HIGH: assert property (
    (wrap_high && timer_irq_enable_ff && irq_mask_ff[art2_pkg::STS_HIGH]
     && !wr_to(paddr, art2_pkg::ADDR_INT_ENABLE, wr_en)
     && !wr_to(paddr, art2_pkg::ADDR_IRQ_MASK, wr_en)) |=> irq)
    else $error("no interrupt on high overflow");

  AST_IRQ_LOW: assert property (
    (wrap_low && !timer_overflow_control_ff[art2_pkg::CTL_LOW_IRQEN] &&
     !irq_status_ff[art2_pkg::STS_LOW])
    |=> !irq_status_ff[art2_pkg::STS_LOW])
    else $error("low interrupt raised while low irq disabled");

  AST_SPLIT_HIGH_RELOAD: assert property (
    (split && wrap_high && !wr_cnt_hi) |=> count_high_byte_ff == $past(reload_high_byte_ff))
    else $error("split high byte did not reload");

  AST_HIGH_FLAG: assert property (
    wrap_high |=> timer_overflow_control_ff[art2_pkg::CTL_HIGH_FLAG])
    else $error("high flag not set on high wrap");

  AST_LOW_FLAG_STICKY: assert property (
    (timer_overflow_control_ff[art2_pkg::CTL_LOW_FLAG] && !wr_ctl)
    |=> timer_overflow_control_ff[art2_pkg::CTL_LOW_FLAG])
    else $error("low flag cleared by hardware");

  AST_SPLIT_IRQ_LOW: assert property (
    (split && wrap_low && timer_overflow_control_ff[art2_pkg::CTL_LOW_IRQEN])
    |=> irq_status_ff[art2_pkg::STS_LOW])
    else $error("split low wrap raised no request");

  AST_HIGH_CARRY_ONLY: assert property (
    (!split && !wrap_low && !wr_cnt_hi) |=> $stable(count_high_byte_ff))
    else $error("16-bit high byte moved without a low carry");

  AST_DIV12_SRC: assert property (
    (!clock_select_ff[art2_pkg::CKS_LOW] && !ext_sel && !sys_tick && !wr_cnt_lo)
    |=> $stable(count_low_byte_ff))
    else $error("low byte moved between divided ticks");

  AST_EXT_SRC: assert property (
    (!clock_select_ff[art2_pkg::CKS_LOW] && ext_sel && !ext_tick && !wr_cnt_lo)
    |=> $stable(count_low_byte_ff))
    else $error("low byte moved between external ticks");

  COV_FULL_WRAP:  cover property (!split && wrap_high);
  COV_SPLIT_BOTH: cover property (split && wrap_low && wrap_high);
  COV_EXT_COUNT:  cover property (ext_sel && ext_tick && inc_low);
  COV_IRQ:        cover property ($rose(irq));
  COV_LOW_IRQ:    cover property (!split && wrap_low &&
                                  timer_overflow_control_ff[art2_pkg::CTL_LOW_IRQEN]);
endmodule
`default_nettype wire

// ### tb/art2_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module art2_top_bench;
  logic                          core_clk;
  logic                          reset;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [art2_pkg::APB_AW-1:0]   paddr;
  logic [art2_pkg::APB_DW-1:0]   pwdata;
  logic [art2_pkg::APB_DW-1:0]   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          ext_osc;
  logic                          irq;
  logic                          osc_en;
  logic [1:0]                    osc_cnt;
  logic [31:0]                   v;
  logic                          err;
  int                            num_errors;
  int                            checked;

  art2_top uut (
    .core_clk (core_clk),
    .reset    (reset),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .ext_osc  (ext_osc),
    .irq      (irq)
  );

  always #10 core_clk = ~core_clk;

  // oscillator period of 8 core cycles, slower than the synchroniser limit
  always @(posedge core_clk) begin
    osc_cnt <= osc_cnt + 2'h1;
    if (osc_en && osc_cnt == 2'h3) begin
      ext_osc <= ~ext_osc;
    end
  end

  task automatic print_verdict;
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rv, output logic re);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a stuck wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    logic        e;
    xfer(1'b1, a, d, t, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] t);
    logic e;
    xfer(1'b0, a, 32'h0000_0000, t, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    rd(a, t);
    `CHK(t, exp)
  endtask

  // irq is combinational from flops: let the last write edge land first
  task automatic chk_irq(input logic exp);
    @(posedge core_clk);
    `CHK(irq, exp)
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    core_clk   = 1'b0;
    reset      = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    ext_osc    = 1'b0;
    osc_en     = 1'b0;
    osc_cnt    = 2'h0;
    num_errors = 0;
    checked    = 0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(4 * i), 32'h0000_0000);
    end
    rd_chk(art2_pkg::ADDR_CONTROL, 32'h0000_0000);
    xfer(1'b0, 8'h20, 32'h0000_0000, v, err);
    `CHK(err, 1'b1)
    `CHK(v, 32'h0000_0000)
    // unused control bits read back as zero
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0012);
    rd_chk(art2_pkg::ADDR_CONTROL, 32'h0000_0000);

    // 16-bit wrap from 0xFFF0 on system clock
    wr(art2_pkg::ADDR_RELOAD_LO, 32'h0000_0034);
    wr(art2_pkg::ADDR_RELOAD_HI, 32'h0000_0012);
    wr(art2_pkg::ADDR_COUNT_LO, 32'h0000_00F0);
    wr(art2_pkg::ADDR_COUNT_HI, 32'h0000_00FF);
    wr(art2_pkg::ADDR_CLK_SELECT, 32'h0000_0001);
    wr(art2_pkg::ADDR_INT_ENABLE, 32'h0000_0001);
    wr(art2_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0004);
    repeat (40) @(posedge core_clk);
    rd_chk(art2_pkg::ADDR_COUNT_HI, 32'h0000_0012);
    rd(art2_pkg::ADDR_CONTROL, v);
    `CHK(v[7:6], 2'b11)
    rd_chk(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    chk_irq(1'b1);
    // stop while keeping both flags stored
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_00C0);
    repeat (200) @(posedge core_clk);
    rd_chk(art2_pkg::ADDR_CONTROL, 32'h0000_00C0);
    rd(art2_pkg::ADDR_COUNT_LO, v);
    repeat (20) @(posedge core_clk);
    rd_chk(art2_pkg::ADDR_COUNT_LO, v);
    wr(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    chk_irq(1'b0);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0000);
    rd_chk(art2_pkg::ADDR_CONTROL, 32'h0000_0000);

    // low-byte wrap request in 16-bit mode, with and without its enable
    wr(art2_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
    wr(art2_pkg::ADDR_COUNT_LO, 32'h0000_00F8);
    wr(art2_pkg::ADDR_COUNT_HI, 32'h0000_0000);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0024);
    repeat (20) @(posedge core_clk);
    rd_chk(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    chk_irq(1'b1);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0020);
    wr(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    wr(art2_pkg::ADDR_COUNT_LO, 32'h0000_00F8);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0004);
    repeat (20) @(posedge core_clk);
    rd_chk(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk_irq(1'b0);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0000);

    // split mode: low byte free running, high byte held until run
    wr(art2_pkg::ADDR_RELOAD_LO, 32'h0000_00F0);
    wr(art2_pkg::ADDR_RELOAD_HI, 32'h0000_0055);
    wr(art2_pkg::ADDR_COUNT_LO, 32'h0000_00FE);
    wr(art2_pkg::ADDR_COUNT_HI, 32'h0000_00FF);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0008);
    repeat (20) @(posedge core_clk);
    rd_chk(art2_pkg::ADDR_COUNT_HI, 32'h0000_00FF);
    rd(art2_pkg::ADDR_CONTROL, v);
    `CHK(v[7:6], 2'b01)
    rd(art2_pkg::ADDR_COUNT_LO, v);
    `CHK(v[7:4], 4'hF)
    rd_chk(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk_irq(1'b0);
    // high byte on the divide-by-12 source while low stays on system clock
    wr(art2_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_000C);
    repeat (30) @(posedge core_clk);
    rd(art2_pkg::ADDR_COUNT_HI, v);
    `CHK(v inside {[32'h55:32'h58]}, 1'b1)
    rd(art2_pkg::ADDR_CONTROL, v);
    `CHK(v[7], 1'b1)
    rd_chk(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    chk_irq(1'b0);
    wr(art2_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
    chk_irq(1'b1);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0008);
    wr(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    chk_irq(1'b0);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0028);
    repeat (20) @(posedge core_clk);
    rd_chk(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    chk_irq(1'b1);
    rd(art2_pkg::ADDR_CONTROL, v);
    `CHK(v[7:6], 2'b01)
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0000);
    wr(art2_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);

    // divide-by-12: high select set but ignored in 16-bit mode
    wr(art2_pkg::ADDR_CLK_SELECT, 32'h0000_0002);
    wr(art2_pkg::ADDR_COUNT_LO, 32'h0000_0000);
    wr(art2_pkg::ADDR_COUNT_HI, 32'h0000_0000);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0004);
    repeat (240) @(posedge core_clk);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0000);
    rd(art2_pkg::ADDR_COUNT_LO, v);
    `CHK(v inside {[32'd19:32'd22]}, 1'b1)
    rd_chk(art2_pkg::ADDR_COUNT_HI, 32'h0000_0000);

    // external source: one count per 8 oscillator rising edges
    wr(art2_pkg::ADDR_CLK_SELECT, 32'h0000_0000);
    wr(art2_pkg::ADDR_COUNT_LO, 32'h0000_0000);
    osc_en <= 1'b1;
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0005);
    repeat (640) @(posedge core_clk);
    wr(art2_pkg::ADDR_CONTROL, 32'h0000_0000);
    osc_en <= 1'b0;
    rd(art2_pkg::ADDR_COUNT_LO, v);
    `CHK(v inside {[32'd9:32'd11]}, 1'b1)
    print_verdict();
  end
endmodule
`default_nettype wire
